// [logic/t16wm_timer.sv]
// waveform mode decode, counter and compare outputs of the 16-bit timer
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ps
module t16wm_timer (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic timer_tick,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic port_a_data,
    input wire logic port_a_dir,
    input wire logic port_b_data,
    input wire logic port_b_dir,
    output logic pin_a_out,
    output logic pin_a_oe,
    output logic pin_b_out,
    output logic pin_b_oe,
    output logic irq
);
    import t16wm_pkg::*;

    logic [7:0] ctrlA_r;
    logic [7:0] ctrlB_r;
    logic [15:0] cmpBufA_r;
    logic [15:0] cmpBufB_r;
    logic [15:0] cmpA_r;
    logic [15:0] cmpB_r;
    logic [15:0] capture_r;
    logic [15:0] count_r;
    logic countDown_r;
    logic waveA_r;
    logic waveB_r;
    logic [3:0] status_r;
    logic [3:0] enable_r;

    // mode decode
    wire [3:0] waveformMode = {ctrlB_r[WGM_HI_HI:WGM_HI_LO],
        ctrlA_r[WGM_LO_HI:WGM_LO_LO]};
    wire [1:0] chanAMode = ctrlA_r[COM_A_HI:COM_A_LO];
    wire [1:0] chanBMode = ctrlA_r[COM_B_HI:COM_B_LO];
    t16wm_family_type family;
    t16wm_update_type updateAt;
    logic [15:0] topVal;
    logic ovfAtBottom;

    // per-mode top source, family and reload moment
    always_comb begin
        family = FAM_SINGLE;
        updateAt = UPD_NOW;
        topVal = MAX_VAL;
        ovfAtBottom = 1'b0;
        unique case (waveformMode)
            WM_NORMAL: topVal = MAX_VAL;
            WM_CTC_A: topVal = cmpA_r;
            WM_CTC_CAP: topVal = capture_r;
            WM_RESERVED: topVal = MAX_VAL;
            WM_PC8, WM_PC9, WM_PC10: begin
                family = FAM_DUAL;
                updateAt = UPD_TOP;
                ovfAtBottom = 1'b1;
                topVal = (waveformMode == WM_PC8) ? TOP_8BIT :
                    (waveformMode == WM_PC9) ? TOP_9BIT : TOP_10BIT;
            end
            WM_FAST8, WM_FAST9, WM_FAST10: begin
                family = FAM_FAST;
                updateAt = UPD_BOTTOM;
                topVal = (waveformMode == WM_FAST8) ? TOP_8BIT :
                    (waveformMode == WM_FAST9) ? TOP_9BIT : TOP_10BIT;
            end
            WM_PFC_CAP, WM_PFC_A: begin
                family = FAM_DUAL;
                updateAt = UPD_BOTTOM;
                ovfAtBottom = 1'b1;
                topVal = (waveformMode == WM_PFC_CAP) ? capture_r : cmpA_r;
            end
            WM_PC_CAP, WM_PC_A: begin
                family = FAM_DUAL;
                updateAt = UPD_TOP;
                ovfAtBottom = 1'b1;
                topVal = (waveformMode == WM_PC_CAP) ? capture_r : cmpA_r;
            end
            WM_FAST_CAP, WM_FAST_A: begin
                family = FAM_FAST;
                updateAt = UPD_BOTTOM;
                topVal = (waveformMode == WM_FAST_CAP) ? capture_r : cmpA_r;
            end
        endcase
    end

    // fixed-top masking of compare writes
    wire fixedTop = (waveformMode == WM_PC8) || (waveformMode == WM_PC9) ||
        (waveformMode == WM_PC10) || (waveformMode == WM_FAST8) ||
        (waveformMode == WM_FAST9) || (waveformMode == WM_FAST10);
    wire [15:0] cmpWrData = fixedTop ? (reg_wdata & topVal)
        : reg_wdata;

    // counter events
    wire atTop = (count_r == topVal);
    wire atBottom = (count_r == BOTTOM_VAL);
    wire atMax = (count_r == MAX_VAL);
    wire isDual = (family == FAM_DUAL);
    wire isFast = (family == FAM_FAST);
    wire countWr = reg_wr && (reg_addr == {1'b0, ADDR_COUNT});
    // dual slope turns at top for exactly one tick, then down
    wire turnDown = isDual && !countDown_r && atTop;
    wire turnUp = isDual && countDown_r && (atBottom || atTop);
    wire nextDown = turnDown ? 1'b1 : (turnUp ? 1'b0 : countDown_r);
    wire [15:0] countNxt = (isDual && nextDown) ? count_r - 16'h0001 :
        ((!isDual && atTop) ? BOTTOM_VAL : count_r + 16'h0001);
    wire tickTop = timer_tick && atTop;
    wire tickBottom = timer_tick && isDual && countDown_r && atBottom;
    wire fastWrap = timer_tick && isFast && atTop;
    wire reloadNow = (updateAt == UPD_TOP) ? tickTop :
        (updateAt == UPD_BOTTOM) ? (isDual ? tickBottom : fastWrap) : 1'b0;
    wire ovfEvent = ovfAtBottom ? tickBottom :
        (isFast ? tickTop : (timer_tick && atMax));
    wire matchA = timer_tick && (count_r == cmpA_r);
    wire matchB = timer_tick && (count_r == cmpB_r);

    // next waveform level for one channel
    function automatic logic waveNext(input logic cur, input logic [1:0] md,
        input logic match, input logic eqTop, input logic isA);
        logic res;
        res = cur;
        if (isFast) begin
            if (md == COM_TOGGLE) begin
                if (isA && match && (waveformMode == WM_FAST_CAP ||
                    waveformMode == WM_FAST_A)) res = !cur;
            end else if (md[1]) begin
                // equal-to-top match ignored, action at top
                if (match && !eqTop) res = (md == COM_SET);
                else if (eqTop && tickTop) res = (md == COM_SET);
                else if (fastWrap) res = (md == COM_CLEAR);
            end
        end else if (isDual) begin
            if (md == COM_TOGGLE) begin
                if (isA && match && (waveformMode == WM_PFC_A ||
                    waveformMode == WM_PC_A)) res = !cur;
            end else if (md[1] && match) begin
                res = (md == COM_SET) ^ countDown_r;
            end
        end else if (match) begin
            unique case (md)
                COM_OFF: res = cur;
                COM_TOGGLE: res = !cur;
                COM_CLEAR: res = 1'b0;
                COM_SET: res = 1'b1;
            endcase
        end
        return res;
    endfunction

    // connection of waveform to pin
    wire connA = (chanAMode != COM_OFF) && !((isFast || isDual) &&
        chanAMode == COM_TOGGLE && !(waveformMode == WM_FAST_CAP ||
        waveformMode == WM_FAST_A || waveformMode == WM_PFC_A ||
        waveformMode == WM_PC_A));
    wire connB = (chanBMode != COM_OFF) &&
        !((isFast || isDual) && chanBMode == COM_TOGGLE);
    wire [3:0] events = {tickTop, matchB, matchA, ovfEvent};
    wire clrWr = reg_wr && (reg_addr == {1'b0, ADDR_IRQ_CLEAR});

    // register read mux
    logic [15:0] rdMux;
    always_comb begin
        rdMux = WORD_RESET;
        unique case (reg_addr)
            {1'b0, ADDR_CTRL_A}: rdMux = {8'h00, ctrlA_r};
            {1'b0, ADDR_CTRL_B}: rdMux = {8'h00, ctrlB_r};
            {1'b0, ADDR_CMP_A}: rdMux = cmpBufA_r;
            {1'b0, ADDR_CMP_B}: rdMux = cmpBufB_r;
            {1'b0, ADDR_CAPTURE}: rdMux = capture_r;
            {1'b0, ADDR_COUNT}: rdMux = count_r;
            {1'b0, ADDR_IRQ_STATUS}: rdMux = {12'h000, status_r};
            ADDR_IRQ_ENABLE: rdMux = {12'h000, enable_r};
            default: rdMux = WORD_RESET;
        endcase
    end

    // control and compare registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrlA_r <= CTRL_RESET;
            ctrlB_r <= CTRL_RESET;
            cmpBufA_r <= WORD_RESET;
            cmpBufB_r <= WORD_RESET;
            capture_r <= WORD_RESET;
            enable_r <= 4'h0;
        end else if (reg_wr) begin
            if (reg_addr == {1'b0, ADDR_CTRL_A}) ctrlA_r <= reg_wdata[7:0];
            if (reg_addr == {1'b0, ADDR_CTRL_B}) ctrlB_r <= reg_wdata[7:0];
            if (reg_addr == {1'b0, ADDR_CMP_A}) cmpBufA_r <= cmpWrData;
            if (reg_addr == {1'b0, ADDR_CMP_B}) cmpBufB_r <= cmpWrData;
            if (reg_addr == {1'b0, ADDR_CAPTURE}) capture_r <= reg_wdata;
            if (reg_addr == ADDR_IRQ_ENABLE) enable_r <= reg_wdata[3:0];
        end
    end

    // active compare values reload from buffers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmpA_r <= WORD_RESET;
            cmpB_r <= WORD_RESET;
        end else if (updateAt == UPD_NOW || reloadNow) begin
            cmpA_r <= cmpBufA_r;
            cmpB_r <= cmpBufB_r;
        end
    end

    // counter steps only on tick enables
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_r <= BOTTOM_VAL;
            countDown_r <= 1'b0;
        end else if (countWr) begin
            count_r <= reg_wdata;
        end else if (timer_tick) begin
            count_r <= countNxt;
            countDown_r <= nextDown;
        end
    end

    // waveform levels
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            waveA_r <= 1'b0;
            waveB_r <= 1'b0;
        end else begin
            waveA_r <= waveNext(waveA_r, chanAMode, matchA,
                cmpA_r == topVal, 1'b1);
            waveB_r <= waveNext(waveB_r, chanBMode, matchB,
                cmpB_r == topVal, 1'b0);
        end
    end

    // sticky status, set wins over clear
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_r <= 4'h0;
        end else begin
            status_r <= (status_r & ~(clrWr ? reg_wdata[3:0] : 4'h0))
                | events;
        end
    end

    // registered outputs
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= WORD_RESET;
            pin_a_out <= 1'b0;
            pin_a_oe <= 1'b0;
            pin_b_out <= 1'b0;
            pin_b_oe <= 1'b0;
            irq <= 1'b0;
        end else begin
            reg_rdata <= reg_rd ? rdMux : WORD_RESET;
            pin_a_out <= connA ? waveA_r : port_a_data;
            pin_a_oe <= port_a_dir;
            pin_b_out <= connB ? waveB_r : port_b_data;
            pin_b_oe <= port_b_dir;
            irq <= |(status_r & enable_r);
        end
    end

    // checks
    dir_gates_a_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        1 |=> pin_a_oe == $past(port_a_dir))
        else $error("pin a enable not from direction");
    dir_gates_b_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        !port_b_dir |=> !pin_b_oe)
        else $error("pin b driven while input");
    port_pass_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        chanAMode == COM_OFF |=> pin_a_out == $past(port_a_data))
        else $error("pin a not returned to port");
    port_pass_b_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        chanBMode == COM_OFF |=> pin_b_out == $past(port_b_data))
        else $error("pin b not returned to port");
    tick_only_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        !timer_tick && !countWr |=> $stable(count_r))
        else $error("counter moved without tick");
    pfc_reload_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (waveformMode == WM_PFC_A || waveformMode == WM_PFC_CAP) &&
        !(tickBottom) |=> $stable(cmpB_r))
        else $error("frequency correct reload off bottom");
    mask_write_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        reg_wr && reg_addr == {1'b0, ADDR_CMP_B} && waveformMode == WM_FAST8
        |=> cmpBufB_r[15:8] == 8'h00)
        else $error("fixed top write not masked");
    toggle_normal_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        waveformMode == WM_NORMAL && chanAMode == COM_TOGGLE && matchA
        |=> waveA_r != $past(waveA_r))
        else $error("normal mode toggle missing");
    fast_clear_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        isFast && chanAMode == COM_CLEAR && matchA && cmpA_r != topVal
        |=> !waveA_r)
        else $error("fast pwm clear on match missing");
    fast_set_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        isFast && chanBMode == COM_SET && matchB && cmpB_r != topVal
        |=> waveB_r)
        else $error("fast pwm set on match missing");
    fast_bottom_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        fastWrap && chanAMode == COM_CLEAR && cmpA_r != topVal
        |=> waveA_r)
        else $error("fast pwm set at bottom missing");
    dual_up_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        isDual && chanBMode == COM_SET && matchB && !countDown_r
        |=> waveB_r)
        else $error("dual slope set on upcount missing");
    dual_down_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        isDual && chanAMode == COM_CLEAR && matchA && countDown_r
        |=> waveA_r)
        else $error("dual slope set on downcount missing");
    top_hold_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        timer_tick && turnDown && !countWr |=> countDown_r)
        else $error("no turn at top");
    top_dwell_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        timer_tick && turnDown && !atBottom && !countWr
        |=> count_r == $past(count_r) - 16'h0001)
        else $error("top held longer than one tick");
    bottom_turn_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        tickBottom && !countWr
        |=> !countDown_r && count_r == 16'h0001)
        else $error("no turn at bottom");
    top_reload_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        updateAt == UPD_TOP && !tickTop |=> $stable(cmpA_r))
        else $error("phase correct reload off top");
    fast_reload_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        isFast && !fastWrap |=> $stable(cmpB_r))
        else $error("fast pwm reload off bottom");
    dual_ovf_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        tickBottom |=> status_r[IRQ_OVF])
        else $error("dual slope overflow missing at bottom");
    fast_ovf_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        isFast && tickTop |=> status_r[IRQ_OVF])
        else $error("fast pwm overflow missing at top");
    no_top_ovf_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        isDual && !tickBottom && !status_r[IRQ_OVF]
        |=> !status_r[IRQ_OVF])
        else $error("dual slope overflow away from bottom");
    toggle_b_off_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (isFast || isDual) && chanBMode == COM_TOGGLE
        |=> pin_b_out == $past(port_b_data))
        else $error("pin b taken by toggle code");
    // main scenario covers
    ovf_cov: cover property (@(posedge core_clk) ovfEvent);
    dual_cov: cover property (@(posedge core_clk) tickBottom && isDual);
    fast_cov: cover property (@(posedge core_clk) fastWrap && connA);
    irq_cov: cover property (@(posedge core_clk) irq);
    turn_cov: cover property (@(posedge core_clk) timer_tick && turnDown);
endmodule : t16wm_timer

// [logic/t16wm_pkg.sv]
// shared constants for the 16-bit timer waveform mode block
package t16wm_pkg;
    // register indices on the plain port
    localparam logic [2:0] ADDR_CTRL_A = 3'h0;
    localparam logic [2:0] ADDR_CTRL_B = 3'h1;
    localparam logic [2:0] ADDR_CMP_A = 3'h2;
    localparam logic [2:0] ADDR_CMP_B = 3'h3;
    localparam logic [2:0] ADDR_CAPTURE = 3'h4;
    localparam logic [2:0] ADDR_COUNT = 3'h5;
    localparam logic [2:0] ADDR_IRQ_STATUS = 3'h6;
    localparam logic [2:0] ADDR_IRQ_CLEAR = 3'h7;
    localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h8;
    // field positions
    localparam int COM_A_HI = 7;
    localparam int COM_A_LO = 6;
    localparam int COM_B_HI = 5;
    localparam int COM_B_LO = 4;
    localparam int WGM_LO_HI = 1;
    localparam int WGM_LO_LO = 0;
    localparam int WGM_HI_HI = 4;
    localparam int WGM_HI_LO = 3;
    // status bit positions
    localparam int IRQ_OVF = 0;
    localparam int IRQ_MATCH_A = 1;
    localparam int IRQ_MATCH_B = 2;
    localparam int IRQ_TOP = 3;
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    // fixed counter values
    localparam logic [15:0] BOTTOM_VAL = 16'h0000;
    localparam logic [15:0] MAX_VAL = 16'hffff;
    localparam logic [15:0] TOP_8BIT = 16'h00ff;
    localparam logic [15:0] TOP_9BIT = 16'h01ff;
    localparam logic [15:0] TOP_10BIT = 16'h03ff;
    // mode codes
    localparam logic [3:0] WM_NORMAL = 4'h0;
    localparam logic [3:0] WM_PC8 = 4'h1;
    localparam logic [3:0] WM_PC9 = 4'h2;
    localparam logic [3:0] WM_PC10 = 4'h3;
    localparam logic [3:0] WM_CTC_A = 4'h4;
    localparam logic [3:0] WM_FAST8 = 4'h5;
    localparam logic [3:0] WM_FAST9 = 4'h6;
    localparam logic [3:0] WM_FAST10 = 4'h7;
    localparam logic [3:0] WM_PFC_CAP = 4'h8;
    localparam logic [3:0] WM_PFC_A = 4'h9;
    localparam logic [3:0] WM_PC_CAP = 4'ha;
    localparam logic [3:0] WM_PC_A = 4'hb;
    localparam logic [3:0] WM_CTC_CAP = 4'hc;
    localparam logic [3:0] WM_RESERVED = 4'hd;
    localparam logic [3:0] WM_FAST_CAP = 4'he;
    localparam logic [3:0] WM_FAST_A = 4'hf;
    // output mode codes
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;
    // counting families
    typedef enum logic [1:0] {
        FAM_SINGLE,
        FAM_FAST,
        FAM_DUAL
    } t16wm_family_type;
    // compare reload moments
    typedef enum logic [1:0] {
        UPD_NOW,
        UPD_TOP,
        UPD_BOTTOM
    } t16wm_update_type;
endpackage : t16wm_pkg

// [bench/testbench.sv]
// self-checking bench for the timer waveform mode block
`timescale 1ns/1ps
module testbench;
    import t16wm_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic timerTick = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWdata = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [15:0] regRdata;
    logic portAData = 1'b0;
    logic portADir = 1'b0;
    logic portBData = 1'b0;
    logic portBDir = 1'b0;
    logic pinAOut, pinAOe, pinBOut, pinBOe, irq;
    int err_count = 0;
    int check_count = 0;
    logic [15:0] rv;
    logic [15:0] v;
    logic ea, eb;
    logic [3:0] mm [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7};
    logic [3:0] tm [4] = '{4'h5, 4'hf, 4'h1, 4'h9};

    t16wm_timer dut (.core_clk(core_clk), .arst_n(arst_n),
        .timer_tick(timerTick), .reg_addr(regAddr), .reg_wdata(regWdata),
        .reg_wr(regWr), .reg_rd(regRd), .reg_rdata(regRdata),
        .port_a_data(portAData), .port_a_dir(portADir),
        .port_b_data(portBData), .port_b_dir(portBDir),
        .pin_a_out(pinAOut), .pin_a_oe(pinAOe), .pin_b_out(pinBOut),
        .pin_b_oe(pinBOe), .irq(irq));

    // free-running core clock
    initial begin
        forever #20 core_clk = ~core_clk;
    end

    task chk(input string name, input logic [15:0] seen,
        input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    function logic [15:0] topMask(input logic [3:0] m, input logic [15:0] d);
        case (m)
            WM_PC8, WM_FAST8: topMask = d & TOP_8BIT;
            WM_PC9, WM_FAST9: topMask = d & TOP_9BIT;
            WM_PC10, WM_FAST10: topMask = d & TOP_10BIT;
            default: topMask = d;
        endcase
    endfunction : topMask

    function logic onMatch(input logic [1:0] c, input logic prev);
        onMatch = (c == COM_TOGGLE) ? ~prev : c[0];
    endfunction : onMatch

    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask : wr

    task rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask : rd

    task doReset;
        arst_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
    endtask : doReset

    task setMode(input logic [3:0] m, input logic [1:0] ca,
        input logic [1:0] cb);
        wr(4'(ADDR_CTRL_A), {8'h00, ca, cb, 2'b00, m[1:0]});
        wr(4'(ADDR_CTRL_B), {11'h000, m[3:2], 3'b000});
    endtask : setMode

    // n timer ticks spread over random gaps
    task run(input int n);
        int k;
        logic t;
        k = n;
        while (k > 0) begin
            @(posedge core_clk);
            t = 1'($urandom);
            timerTick <= t;
            if (t) k--;
        end
        @(posedge core_clk);
        timerTick <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask : run

    task chkPins(input logic a, input logic b);
        chk("pin A", {15'h0000, pinAOut}, {15'h0000, a});
        chk("pin B", {15'h0000, pinBOut}, {15'h0000, b});
    endtask : chkPins

    task results;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    // hang guard
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        $display("Error watchdog expected done seen hang");
        results;
    end

    initial begin
        void'($urandom(53));
        portAData <= 1'($urandom);
        portBData <= 1'($urandom);
        doReset;
        rd(4'(ADDR_CTRL_A), rv);
        chk("ctrl A", rv, 16'h0000);
        rd(4'(ADDR_CTRL_B), rv);
        chk("ctrl B", rv, 16'h0000);
        chkPins(portAData, portBData);
        chk("oe A", {15'h0000, pinAOe}, 16'h0000);
        $display("test reset done");
        @(posedge core_clk);
        portADir <= 1'b1;
        portBDir <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1 chk("oe A", {15'h0000, pinAOe}, 16'h0001);
        chk("oe B", {15'h0000, pinBOe}, 16'h0001);
        setMode(WM_NORMAL, COM_SET, COM_SET);
        portADir <= 1'b0;
        portBDir <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1 chk("oe A", {15'h0000, pinAOe}, 16'h0000);
        chk("oe B", {15'h0000, pinBOe}, 16'h0000);
        @(posedge core_clk);
        portADir <= 1'b1;
        portBDir <= 1'b1;
        $display("test direction done");
        // control readback and unmapped places
        repeat (4) begin
            v = {8'h00, 8'($urandom)};
            wr(4'(ADDR_CTRL_A), v);
            rd(4'(ADDR_CTRL_A), rv);
            chk("ctrl A", rv, v);
        end
        for (int a = 9; a < 16; a++) begin
            wr(4'(a), 16'($urandom));
            rd(4'(a), rv);
            chk("unmapped", rv, 16'h0000);
        end
        // fixed top masking per mode
        foreach (mm[i]) begin
            setMode(mm[i], COM_OFF, COM_OFF);
            v = 16'($urandom);
            wr(4'(ADDR_CMP_A), v);
            rd(4'(ADDR_CMP_A), rv);
            chk("cmp A", rv, topMask(mm[i], v));
        end
        $display("test registers done");
        // non pwm codes in normal and capture top clear mode
        wr(4'(ADDR_CAPTURE), 16'hffff);
        for (int m = 0; m < 2; m++) begin
            for (int c = 3; c > 0; c--) begin
                setMode(m ? WM_CTC_CAP : WM_NORMAL, 2'(c), 2'(c));
                wr(4'(ADDR_CMP_A), 16'h0008);
                wr(4'(ADDR_CMP_B), 16'h0004);
                wr(4'(ADDR_COUNT), 16'h0000);
                repeat (3) @(posedge core_clk);
                #1 ea = onMatch(2'(c), pinAOut);
                eb = onMatch(2'(c), pinBOut);
                run(12);
                chkPins(ea, eb);
            end
        end
        $display("test non pwm done");
        setMode(WM_FAST8, COM_CLEAR, COM_SET);
        wr(4'(ADDR_CMP_A), 16'h0010);
        // high byte of the compare must mask away in 8-bit fast mode
        wr(4'(ADDR_CMP_B), 16'hab10);
        wr(4'(ADDR_COUNT), 16'h00f8);
        run(16);
        chkPins(1'b1, 1'b0);
        run(16);
        chkPins(1'b0, 1'b1);
        $display("test fast pwm done");
        // toggle code only reaches channel A in two modes per family
        foreach (tm[i]) begin
            setMode(tm[i], COM_TOGGLE, COM_TOGGLE);
            portAData <= 1'($urandom);
            portBData <= 1'($urandom);
            repeat (3) @(posedge core_clk);
            #1 chk("pin B", {15'h0000, pinBOut},
                {15'h0000, portBData});
            if (tm[i] == WM_FAST8 || tm[i] == WM_PC8) begin
                chk("pin A", {15'h0000, pinAOut},
                    {15'h0000, portAData});
            end
        end
        $display("test toggle code done");
        // dual slope after a second reset
        @(posedge core_clk);
        doReset;
        wr(4'(ADDR_CMP_A), 16'h0010);
        wr(4'(ADDR_CMP_B), 16'h0010);
        setMode(WM_PC8, COM_CLEAR, COM_SET);
        run(32);
        chkPins(1'b0, 1'b1);
        run(468);
        chkPins(1'b1, 1'b0);
        rd(4'(ADDR_COUNT), rv);
        chk("count", rv, 16'h000a);
        rd(4'(ADDR_IRQ_STATUS), rv);
        chk("ovf top", rv & 16'h0001, 16'h0000);
        run(20);
        rd(4'(ADDR_IRQ_STATUS), rv);
        chk("ovf bottom", rv & 16'h0001, 16'h0001);
        wr(4'(ADDR_IRQ_ENABLE), 16'h0001);
        repeat (2) @(posedge core_clk);
        #1 chk("irq on", {15'h0000, irq}, 16'h0001);
        wr(4'(ADDR_IRQ_ENABLE), 16'h0000);
        repeat (2) @(posedge core_clk);
        #1 chk("irq masked", {15'h0000, irq}, 16'h0000);
        wr(4'(ADDR_IRQ_CLEAR), 16'h0001);
        wr(4'(ADDR_IRQ_ENABLE), 16'h0001);
        rd(4'(ADDR_IRQ_STATUS), rv);
        chk("ovf clear", rv & 16'h0001, 16'h0000);
        #1 chk("irq off", {15'h0000, irq}, 16'h0000);
        $display("test dual slope done");
        results;
    end
endmodule : testbench
